// [msc_defs.svh]
// Constants for the module sideband and management control block
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_DEV_ADDR 7'h50
`define MSC_CLK_NS 5
`define MSC_RST_MIN_NS 10000
`define MSC_RST_MIN_CYC ((`MSC_RST_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_INIT_NS 2000000
`define MSC_INIT_CYC (`MSC_INIT_NS / `MSC_CLK_NS)
`define MSC_OFS_ID 8'h00
`define MSC_OFS_STATUS 8'h01
`define MSC_OFS_FLAGS 8'h02
`define MSC_OFS_POWER 8'h03
`define MSC_USER_PAGE 4'h1
`define MSC_USER_RST 8'h00
`define MSC_BIT_INIT 0
`define MSC_FLAG_FAULT 0
`define MSC_FLAG_DONE 1
`endif

// [msc_host_bfm.sv]
// Two-wire bus master model of the host board controller
module msc_host_bfm (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o,
   output logic res_valid_o,
   output logic [8:0] res_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      res_valid_o = 1'b0;
      res_o = 9'h000;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // SDA moves only with SCL low; setup and low time leave room for the slave answer
   task automatic bit_x(input logic b, output logic s);
      tick(2);
      sda_pull_o = ~b;
      tick(3);
      scl_o = 1'b1;
      tick(3);
      s = sda_i;
      tick(1);
      scl_o = 1'b0;
   endtask
   task automatic start_c();
      tick(2);
      sda_pull_o = 1'b0;
      tick(3);
      scl_o = 1'b1;
      tick(3);
      sda_pull_o = 1'b1;
      tick(3);
      scl_o = 1'b0;
   endtask
   task automatic stop_c();
      tick(2);
      sda_pull_o = 1'b1;
      tick(3);
      scl_o = 1'b1;
      tick(3);
      sda_pull_o = 1'b0;
      tick(4);
   endtask
   // Byte out, ninth bit from a9; result is acknowledge and wire bits
   task automatic xfer(input logic [7:0] d, input logic a9);
      logic [7:0] r;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
         r[i] = s;
      end
      bit_x(a9, s);
      res_o = {~s, r};
      res_valid_o = 1'b1;
      tick(1);
      res_valid_o = 1'b0;
   endtask
endmodule // msc_host_bfm

// [msc_pkg.sv]
// Types for the module sideband and management control block
package msc_pkg;
   typedef enum logic [2:0] {
      msc_st_idle = 3'b000,
      msc_st_addr = 3'b001,
      msc_st_reg = 3'b010,
      msc_st_wdata = 3'b011,
      msc_st_ack = 3'b100,
      msc_st_rdata = 3'b101,
      msc_st_rack = 3'b110
   } msc_state_t;

   typedef struct packed {
      msc_state_t st;
      msc_state_t ret;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic ack_ok;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic sda_out;
      logic [15:0] rst_cnt;
      logic armed;
      logic init_pending;
      logic [31:0] init_cnt;
      logic [7:0] flags;
      logic int_oe;
      logic int_n;
      logic pres_n;
      logic lp;
      logic [15:0][7:0] user;
   } msc_regs_t;
endpackage : msc_pkg

// [msc_sideband.sv]
// Sideband pins and two-wire management slave of a pluggable cable module
`include "msc_defs.svh"

// Behaviour
// RQ1: Module select low lets the two-wire slave accept and answer transfers.
// RQ2: Module select high makes the slave ignore all two-wire traffic.
// RQ3: An undriven select reads high by pull-up, so the module stays deselected.
// RQ4: Reset pin low beyond minimum pulse restores every user setting to default.
// RQ5: Reset completion time is counted from the rising edge ending reset low.
// RQ6: Host ignores status bits during reset until completion interrupt appears.
// RQ7: Reset end raises the interrupt with the init-pending flag negated.
// RQ8: Power-up posts the reset-completion interrupt without a reset pin pulse.
// RQ9: Low-power request high puts the module into its reduced-power state.
// RQ10: Presence output reads low while the module sits in the connector.
// RQ11: Interrupt pin is pulled low for a fault or a critical status.
// RQ12: Host reads status over the two-wire bus to find the interrupt cause.
// RQ13: Slave answers at seven-bit address 1010000, low address bit selects read.
// RQ14: Interrupt holds until its flags are read, then floats, never driven high.
// RQ15: Init-pending flag reads set during reset, clear once defaults are restored.
module msc_sideband #(
   parameter int INIT_CYCLES = `MSC_INIT_CYC,
   parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic module_select_n_i,
   input wire logic module_reset_n_i,
   input wire logic low_power_request_i,
   input wire logic fault_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic interrupt_n_o,
   output logic interrupt_oe_o,
   output logic presence_n_o,
   output logic low_power_o
);

   // ---------------------------------------------------------------
   // State and events
   // ---------------------------------------------------------------
   msc_pkg::msc_regs_t q;
   msc_pkg::msc_regs_t next_q;
   msc_pkg::msc_regs_t rst_val;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] rd_byte;

   assign scl_rise = scl_i & ~q.scl_q;
   assign scl_fall = ~scl_i & q.scl_q;
   assign bus_start = scl_i & q.scl_q & q.sda_q & ~sda_i;
   assign bus_stop = scl_i & q.scl_q & ~q.sda_q & sda_i;

   always_comb begin
      rst_val = '0;
      rst_val.scl_q = 1'b1;
      rst_val.sda_q = 1'b1;
      rst_val.init_pending = 1'b1;
   end

   // ---------------------------------------------------------------
   // Read data mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (q.ptr == `MSC_OFS_ID) begin
         rd_byte = ID_CODE;
      end else if (q.ptr == `MSC_OFS_STATUS) begin
         rd_byte[`MSC_BIT_INIT] = q.init_pending;
      end else if (q.ptr == `MSC_OFS_FLAGS) begin
         rd_byte = q.flags;
      end else if (q.ptr == `MSC_OFS_POWER) begin
         rd_byte[0] = q.lp;
      end else if (q.ptr[7:4] == `MSC_USER_PAGE) begin
         rd_byte = q.user[q.ptr[3:0]];
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.scl_q = scl_i;
      next_q.sda_q = sda_i;
      // RQ9 low power follow
      next_q.lp = low_power_request_i;

      // RQ4 minimum pulse timer
      if (!module_reset_n_i) begin
         if (q.rst_cnt != 16'(`MSC_RST_MIN_CYC)) begin
            next_q.rst_cnt = q.rst_cnt + 16'h0001;
         end else begin
            next_q.armed = 1'b1;
         end
      end else begin
         next_q.rst_cnt = 16'h0000;
         next_q.armed = 1'b0;
      end

      // RQ15 init timer counts up
      if (q.init_pending) begin
         if (q.init_cnt == 32'(INIT_CYCLES - 1)) begin
            next_q.init_pending = 1'b0;
         end else begin
            next_q.init_cnt = q.init_cnt + 32'h1;
         end
      end

      // RQ2 deselected bus ignored
      // RQ3 undriven select stays deselected
      if (module_select_n_i) begin
         next_q.st = msc_pkg::msc_st_idle;
         next_q.sda_oe = 1'b0;
      end else if (bus_stop) begin
         next_q.st = msc_pkg::msc_st_idle;
         next_q.sda_oe = 1'b0;
      end else if (bus_start) begin
         // RQ1 selected start taken
         next_q.st = msc_pkg::msc_st_addr;
         next_q.bitc = 4'h0;
         next_q.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            msc_pkg::msc_st_idle: begin
            end
            msc_pkg::msc_st_addr, msc_pkg::msc_st_reg, msc_pkg::msc_st_wdata: begin
               if (scl_rise) begin
                  next_q.sh = {q.sh[6:0], sda_i};
                  next_q.bitc = q.bitc + 4'h1;
               end else if (scl_fall && q.bitc == 4'h8) begin
                  next_q.bitc = 4'h0;
                  next_q.st = msc_pkg::msc_st_ack;
                  next_q.sda_oe = 1'b1;
                  next_q.ret = msc_pkg::msc_st_wdata;
                  if (q.st == msc_pkg::msc_st_addr) begin
                     // RQ13 address match
                     if (q.sh[7:1] != `MSC_DEV_ADDR) begin
                        next_q.st = msc_pkg::msc_st_idle;
                        next_q.sda_oe = 1'b0;
                     end else if (q.sh[0]) begin
                        next_q.ret = msc_pkg::msc_st_rdata;
                     end else begin
                        next_q.ret = msc_pkg::msc_st_reg;
                     end
                  end else if (q.st == msc_pkg::msc_st_reg) begin
                     next_q.ptr = q.sh;
                  end else begin
                     // Only the user page is writable; other bytes ack and drop
                     if (q.ptr[7:4] == `MSC_USER_PAGE) begin
                        next_q.user[q.ptr[3:0]] = q.sh;
                     end
                     next_q.ptr = q.ptr + 8'h01;
                  end
               end
            end
            msc_pkg::msc_st_ack: begin
               if (scl_fall) begin
                  next_q.sda_oe = 1'b0;
                  next_q.st = q.ret;
                  next_q.bitc = 4'h0;
                  if (q.ret == msc_pkg::msc_st_rdata) begin
                     next_q.sh = rd_byte;
                     next_q.sda_oe = ~rd_byte[7];
                     // RQ14 read clears flags
                     if (q.ptr == `MSC_OFS_FLAGS) begin
                        next_q.flags = 8'h00;
                     end
                  end
               end
            end
            msc_pkg::msc_st_rdata: begin
               if (scl_rise) begin
                  next_q.bitc = q.bitc + 4'h1;
               end else if (scl_fall) begin
                  if (q.bitc == 4'h8) begin
                     next_q.sda_oe = 1'b0;
                     next_q.st = msc_pkg::msc_st_rack;
                     next_q.ptr = q.ptr + 8'h01;
                  end else begin
                     next_q.sh = {q.sh[6:0], 1'b0};
                     next_q.sda_oe = ~q.sh[6];
                  end
               end
            end
            msc_pkg::msc_st_rack: begin
               if (scl_rise) begin
                  next_q.ack_ok = ~sda_i;
               end else if (scl_fall) begin
                  if (q.ack_ok) begin
                     next_q.st = msc_pkg::msc_st_rdata;
                     next_q.bitc = 4'h0;
                     next_q.sh = rd_byte;
                     next_q.sda_oe = ~rd_byte[7];
                     if (q.ptr == `MSC_OFS_FLAGS) begin
                        next_q.flags = 8'h00;
                     end
                  end else begin
                     next_q.st = msc_pkg::msc_st_idle;
                  end
               end
            end
            default: begin
               next_q.st = msc_pkg::msc_st_idle;
               next_q.sda_oe = 1'b0;
            end
         endcase
      end

      // RQ11 fault sets flag
      // Set after the read-clear so an event in the clearing cycle survives
      if (fault_i) begin
         next_q.flags[`MSC_FLAG_FAULT] = 1'b1;
      end
      // RQ7 completion flag
      if (q.init_pending && !next_q.init_pending) begin
         next_q.flags[`MSC_FLAG_DONE] = 1'b1;
      end

      // RQ4 hold defaults in reset
      // RQ5 timing restarts at release
      if (q.armed && !module_reset_n_i) begin
         next_q.user = '0;
         next_q.flags = 8'h00;
         next_q.init_pending = 1'b1;
         next_q.init_cnt = 32'h0;
         next_q.st = msc_pkg::msc_st_idle;
         next_q.sda_oe = 1'b0;
      end

      // RQ14 open drain, low only
      next_q.int_oe = |next_q.flags;
      next_q.int_n = 1'b0;
      // RQ10 presence tied low
      next_q.pres_n = 1'b0;
      next_q.sda_out = 1'b0;
   end

   // RQ8 power-up starts init
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         q <= rst_val;
      end else begin
         q <= next_q;
      end
   end

   assign sda_o = q.sda_out;
   assign sda_oe_o = q.sda_oe;
   assign interrupt_n_o = q.int_n;
   assign interrupt_oe_o = q.int_oe;
   assign presence_n_o = q.pres_n;
   assign low_power_o = q.lp;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence s_reset_release;
      q.armed && module_reset_n_i;
   endsequence

   sequence s_init_fall;
      q.init_pending ##1 !q.init_pending;
   endsequence

   a_desel_quiet: assert property (module_select_n_i |=> !sda_oe_o) // RQ2
      else $error("Deselected module drives the data line");
   a_desel_pullup: assert property (module_select_n_i[*2] |-> q.st == msc_pkg::msc_st_idle) // RQ3
      else $error("Deselected module left idle state");
   a_start_taken: assert property (!module_select_n_i && bus_start && !bus_stop // RQ1
      |=> q.st == msc_pkg::msc_st_addr && q.bitc == 4'h0)
      else $error("Selected start condition not taken");
   a_addr_ack: assert property ($rose(sda_oe_o) && q.st == msc_pkg::msc_st_ack // RQ13
      && q.ret != msc_pkg::msc_st_wdata |-> $past(q.sh[7:1]) == `MSC_DEV_ADDR)
      else $error("Acknowledge given to a foreign address");
   // Counter already reads one a cycle after release: counting starts at the release edge
   a_reset_defaults: assert property (s_reset_release // RQ4
      |-> q.user == '0 && q.init_pending ##1 q.init_cnt == 32'h1)
      else $error("Reset did not restore defaults");
   a_init_from_edge: assert property (s_reset_release ##1 module_reset_n_i[*3] // RQ5
      |-> q.init_cnt == 32'h3 || !q.init_pending)
      else $error("Init time not counted from the reset release");
   a_done_int: assert property (s_init_fall |-> q.flags[`MSC_FLAG_DONE] && interrupt_oe_o) // RQ7
      else $error("Reset end did not post the completion interrupt");
   a_power_up: assert property ($rose(resetn_i) |-> q.init_pending) // RQ8
      else $error("Power-up did not start initialisation");
   a_low_power: assert property (low_power_request_i |=> low_power_o) // RQ9
      else $error("Low-power request not followed");
   a_present: assert property (presence_n_o == 1'b0) // RQ10
      else $error("Presence output not low");
   a_fault_int: assert property (fault_i && !(q.armed && !module_reset_n_i) // RQ11
      |=> interrupt_oe_o && q.flags[`MSC_FLAG_FAULT])
      else $error("Fault did not raise the interrupt");
   a_int_open_drain: assert property (interrupt_n_o == 1'b0 // RQ14
      && (interrupt_oe_o == (q.flags != 8'h00)))
      else $error("Interrupt pin not open drain or out of step with flags");
   a_init_flag: assert property (q.armed && !module_reset_n_i |=> q.init_pending) // RQ15
      else $error("Init-pending flag clear during reset");

endmodule // msc_sideband

// [msc_sideband_test.sv]
// Self-checking bench of the sideband pins and two-wire management slave
`include "msc_defs.svh"
module msc_sideband_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   localparam int INIT_N = 2000;
   localparam logic [7:0] ID_V = 8'h3c; // Arbitrary value
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sel_en = 1'b1;
   logic sel_val = 1'b0;
   logic mod_rst_n = 1'b1;
   logic lp_req = 1'b0;
   logic fault = 1'b0;
   logic scl, sda_pull, sda_o, sda_oe, int_n, int_oe, pres_n, lp_o, res_v;
   logic [8:0] res;
   logic [8:0] exp_q[$];
   logic [31:0] seed = 32'h88c2348e;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   wire sel_n = sel_en ? sel_val : 1'b1;
   wire sda = ~(sda_pull | (sda_oe & ~sda_o));
   wire int_pin = int_oe ? int_n : 1'b1;
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   msc_sideband #(.INIT_CYCLES(INIT_N), .ID_CODE(ID_V)) dut_u (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .module_select_n_i(sel_n),
      .module_reset_n_i(mod_rst_n), .low_power_request_i(lp_req), .fault_i(fault),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .interrupt_n_o(int_n),
      .interrupt_oe_o(int_oe), .presence_n_o(pres_n), .low_power_o(lp_o));
   msc_host_bfm host_u (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull),
      .res_valid_o(res_v), .res_o(res));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check_byte(input logic [8:0] e, input logic [8:0] s);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value bus byte expected %h seen %h", e, s);
      end
   endtask
   task automatic check_bit(input string n, input logic e, input logic s);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", n, e, s);
      end
   endtask
   always @(posedge clk_sys_i) begin
      if (res_v === 1'b1) begin
         if (exp_q.size() > 0) begin
            check_byte(exp_q.pop_front(), res);
         end else begin
            check_byte(9'h000, ~res);
         end
      end
   end
   task automatic send(input logic [7:0] d, input logic ack);
      exp_q.push_back({ack, d});
      host_u.xfer(d, 1'b1);
   endtask
   task automatic recv(input logic [7:0] e, input logic last);
      exp_q.push_back({~last, e});
      host_u.xfer(8'hff, last);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      host_u.start_c();
      send(8'ha0, 1'b1);
      send(p, 1'b1);
      foreach (d[i]) send(d[i], 1'b1);
      host_u.stop_c();
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
      host_u.start_c();
      send(8'ha0, 1'b1);
      send(p, 1'b1);
      host_u.start_c();
      send(8'ha1, 1'b1);
      foreach (e[i]) recv(e[i], i == e.size() - 1);
      host_u.stop_c();
   endtask
   task automatic wait_to(input int t);
      while (cyc < t) @(negedge clk_sys_i);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [7:0] u[$];
      logic [31:0] r;
      int t0;
      repeat (8) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t0 = cyc;
      check_bit("presence", 1'b0, pres_n);
      wait_to(t0 + INIT_N - 10);
      check_bit("interrupt pin", 1'b1, int_pin);
      wait_to(t0 + INIT_N + 10);
      check_bit("interrupt pin", 1'b0, int_pin);
      rd(8'h00, '{ID_V, 8'h00});
      check_bit("interrupt pin", 1'b0, int_pin);
      rd(8'h02, '{8'h02});
      check_bit("interrupt pin", 1'b1, int_pin);
      $display("test power up done");
      for (int k = 0; k < 7; k++) begin
         host_u.start_c();
         send(8'ha0 ^ (8'h02 << k), 1'b0);
         host_u.stop_c();
      end
      // Writes outside the user page are acknowledged and dropped
      wr(8'h00, '{8'hc3});
      rd(8'h00, '{ID_V});
      $display("test address done");
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         u.push_back(r[7:0]);
      end
      wr(8'h1c, u);
      rd(8'h1c, u);
      for (int k = 0; k < 2; k++) begin
         sel_en = k[0];
         sel_val = 1'b1;
         host_u.start_c();
         send(8'ha0, 1'b0);
         send(8'h1c, 1'b0);
         send(8'h55, 1'b0);
         host_u.stop_c();
      end
      sel_val = 1'b0;
      rd(8'h1c, u);
      $display("test select done");
      mod_rst_n = 1'b0;
      repeat (`MSC_RST_MIN_CYC - 50) @(negedge clk_sys_i);
      mod_rst_n = 1'b1;
      rd(8'h1c, u);
      fault = 1'b1;
      @(negedge clk_sys_i);
      fault = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      check_bit("interrupt pin", 1'b0, int_pin);
      rd(8'h02, '{8'h01});
      check_bit("interrupt pin", 1'b1, int_pin);
      fault = 1'b1;
      @(negedge clk_sys_i);
      fault = 1'b0;
      mod_rst_n = 1'b0;
      repeat (`MSC_RST_MIN_CYC + 10) @(negedge clk_sys_i);
      check_bit("interrupt pin", 1'b1, int_pin);
      mod_rst_n = 1'b1;
      t0 = cyc;
      // only the pending flag is looked at before completion
      rd(8'h01, '{8'h01});
      wait_to(t0 + INIT_N - 10);
      check_bit("interrupt pin", 1'b1, int_pin);
      wait_to(t0 + INIT_N + 10);
      check_bit("interrupt pin", 1'b0, int_pin);
      rd(8'h01, '{8'h00, 8'h02, 8'h00});
      rd(8'h1c, '{8'h00, 8'h00, 8'h00, 8'h00});
      $display("test reset done");
      for (int k = 0; k < 40; k++) begin
         r = rnd();
         lp_req = r[0];
         @(negedge clk_sys_i);
         check_bit("low power", lp_req, lp_o);
      end
      lp_req = 1'b1;
      rd(8'h03, '{8'h01});
      $display("test low power done");
      check_bit("queue empty", 1'b1, exp_q.size() == 0);
      complete_run();
   end
   // Over two and a half times the expected length of the whole sequence
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      n_errors++;
      complete_run();
   end
endmodule // msc_sideband_test
